// [design/rerc_map.svh]
`ifndef RERC_MAP_SVH
`define RERC_MAP_SVH

// register byte offsets on the bus
`define RERC_CTRL_ADDR 8'h00
`define RERC_MASK_ADDR 8'h04
`define RERC_STATUS_ADDR 8'h08
`define RERC_ADDR_W 8

// control register fields
`define RERC_CTRL_AUX_BIT 0
`define RERC_CTRL_RESET 1'h0

// mask register fields, a one lets the source through
`define RERC_MASK_SUPPLY_BIT 0
`define RERC_MASK_FAULT_BIT 1
`define RERC_MASK_RESET 2'h0

// status register fields
`define RERC_STAT_RAIL_LSB 0
`define RERC_STAT_RESET_BIT 8
`define RERC_STAT_MANUAL_BIT 9
`define RERC_STAT_PHASE_LSB 10
`define RERC_STAT_SUPPLY_BIT 12
`define RERC_STAT_FAULT_BIT 13
`define RERC_STAT_IRQ_BIT 14

// reset time-out length in core cycles
`define RERC_RESET_TIMEOUT_CYCLES 4000

`endif

// [design/rerc_pkg.sv]
package rerc_pkg;

    // power-up phases of the sequencer
    typedef enum logic [1:0] {
        PH_OFF,
        PH_RAMP,
        PH_BOOT,
        PH_RUN
    } rerc_phase_t;

    // complete state of the top module
    typedef struct packed {
        rerc_phase_t phase;
        logic manual;
        logic aux_sw;
        logic [1:0] mask;
        logic [6:0] rail;
        logic rst_oe;
        logic btn_oe;
        logic irq_oe;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
        logic [31:0] hrdata;
    } rerc_state_t;

endpackage : rerc_pkg

// [design/rerc_sync.sv]
`timescale 1ns/1ps

// two-flop synchroniser for a group of pin levels
module rerc_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    // first stage is read only by the second stage
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rerc_sync_state_t;

    rerc_sync_state_t s;
    rerc_sync_state_t next_s;

    // shift one stage per edge
    always_comb
    begin
        next_s.s1 = i_d;
        next_s.s2 = s.s1;
    end

    // synchronous clear to idle levels
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_q = s.s2;

endmodule : rerc_sync

// [design/rerc_timer.sv]
`timescale 1ns/1ps

// reset time-out counter, restartable
module rerc_timer #(
    parameter int COUNT = 4000
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    output logic o_done
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    // counter value and expiry flag
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
    } rerc_timer_state_t;

    rerc_timer_state_t s;
    rerc_timer_state_t next_s;

    // clear wins, else count up to expiry and stick
    always_comb
    begin
        next_s = s;
        if (i_clear)
        begin
            next_s.cnt = '0;
            next_s.done = 1'b0;
        end
        else if (!s.done)
        begin
            next_s.cnt = s.cnt + CW'(1);
            next_s.done = (s.cnt == LAST);
        end
    end

    // expired after reset so no stale time-out is pending
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            s <= '{cnt: '0, done: 1'b1};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_done = s.done;

endmodule : rerc_timer

// [design/rerc_top.sv]
// Summary of operation
// - hold only: channels 1,2,5 on, rest off unless AUX_FOLLOWS_HOLD adds 6,7
// - hold and core: channels 1-5 on
// - plus software aux enable: all seven on
// - hold and core both low, button released: all off
// - button/hold drive 1,2,5, and 6,7 with AUX_FOLLOWS_HOLD; core drives 3,4
// - hard press resets, soft press enables system
// - hard press: reset low until release+time-out
// - button status open-drain low while pressed
// - startup reset released time-out after channel-1 ok
// - interrupt open-drain low on unmasked condition
// - interrupt sources masked after reset
// - channel 1 first, then 2,5 with reset
// - button released without take-over: abort, all off
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rerc_map.svh"

module rerc_top
    import rerc_pkg::*;
#(
    parameter int RESET_TIMEOUT_CYCLES = `RERC_RESET_TIMEOUT_CYCLES,
    parameter bit AUX_FOLLOWS_HOLD = 1'b0
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_HOLD_RAIL_ENABLE,
    input wire logic I_CORE_RAIL_ENABLE,
    input wire logic I_PUSH_BUTTON_IN_N,
    input wire logic I_BUTTON_HARD_PULL,
    input wire logic I_CH1_POWER_OK,
    input wire logic I_SUPPLY_LOW,
    input wire logic I_FAULT,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic [6:0] O_RAIL_ENABLE,
    output logic O_PROCESSOR_RESET_OUT_N,
    output logic O_PROCESSOR_RESET_OUT_N_OE,
    output logic O_BUTTON_STATE_OUT_N,
    output logic O_BUTTON_STATE_OUT_N_OE,
    output logic O_INTERRUPT_OUT_N,
    output logic O_INTERRUPT_OUT_N_OE
);

    // rail masks, bit 0 is channel 1
    localparam logic [6:0] HOLD_RAILS = 7'h13;
    localparam logic [6:0] CORE_RAILS = 7'h0c;
    localparam logic [6:0] AUX_RAILS = 7'h60;
    localparam logic [6:0] CH1_RAIL = 7'h01;

    rerc_state_t s; // all registered state
    rerc_state_t next_s; // its next value
    logic [6:0] pins; // synchronised pin levels
    logic hold; // processor hold request
    logic core; // processor core request
    logic pressed; // button asserted, any impedance
    logic hard; // button pulled hard to ground
    logic pok; // channel 1 reached power-ok
    logic supply_low; // supply monitor below threshold
    logic fault; // fault condition from monitors
    logic timer_done; // reset time-out expired
    logic timer_clear; // restart the time-out
    logic addr_phase; // bus address phase taken
    logic [31:0] rd_word; // read data for the current address

    // every pin is asynchronous to the core clock
    rerc_sync #(
        .W(7)
    ) u_sync (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_d({I_FAULT, I_SUPPLY_LOW, I_CH1_POWER_OK, I_BUTTON_HARD_PULL,
              ~I_PUSH_BUTTON_IN_N, I_CORE_RAIL_ENABLE, I_HOLD_RAIL_ENABLE}),
        .o_q(pins)
    );

    assign hold = pins[0];
    assign core = pins[1];
    assign pressed = pins[2];
    assign hard = pins[3] & pins[2]; // hard only counts while pressed
    assign pok = pins[4];
    assign supply_low = pins[5];
    assign fault = pins[6];

    // one counter serves startup and manual reset
    rerc_timer #(
        .COUNT(RESET_TIMEOUT_CYCLES)
    ) u_timer (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_clear(timer_clear),
        .o_done(timer_done)
    );

    // rails that the hold-type inputs bring up
    function automatic logic [6:0] hold_set(input logic on);
        hold_set = on ? (HOLD_RAILS | (AUX_FOLLOWS_HOLD ? AUX_RAILS : 7'h00)) : 7'h00;
    endfunction : hold_set

    // status word seen by software
    function automatic logic [31:0] status_word(input rerc_state_t st, input logic sl, input logic fl);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`RERC_STAT_RAIL_LSB +: 7] = st.rail;
        w[`RERC_STAT_RESET_BIT] = st.rst_oe;
        w[`RERC_STAT_MANUAL_BIT] = st.manual;
        w[`RERC_STAT_PHASE_LSB +: 2] = st.phase;
        w[`RERC_STAT_SUPPLY_BIT] = sl;
        w[`RERC_STAT_FAULT_BIT] = fl;
        w[`RERC_STAT_IRQ_BIT] = st.irq_oe;
        status_word = w;
    endfunction : status_word

    // a transfer is taken only when the bus is ready
    assign addr_phase = I_HSEL & I_HTRANS[1] & I_HREADY;

    // read mux, unmapped words read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (I_HADDR[`RERC_ADDR_W-1:0])
            `RERC_CTRL_ADDR:
            begin
                rd_word[`RERC_CTRL_AUX_BIT] = s.aux_sw;
            end
            `RERC_MASK_ADDR:
            begin
                rd_word[1:0] = s.mask;
            end
            `RERC_STATUS_ADDR:
            begin
                rd_word = status_word(s, supply_low, fault);
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // restart on entry to boot, hold at zero while hard pressed
    assign timer_clear = (s.phase == PH_RAMP && pok) || (s.phase != PH_OFF && hard);

    // sequencer, rails, open-drain drives and register writes
    always_comb
    begin
        next_s = s;

        // bus data phase: write lands now, read data registered
        next_s.dph = addr_phase;
        next_s.dwr = addr_phase & I_HWRITE;
        next_s.daddr = I_HADDR[`RERC_ADDR_W-1:0];
        if (addr_phase && !I_HWRITE)
        begin
            next_s.hrdata = rd_word;
        end
        if (s.dph && s.dwr)
        begin
            if (s.daddr == `RERC_CTRL_ADDR)
            begin
                next_s.aux_sw = I_HWDATA[`RERC_CTRL_AUX_BIT];
            end
            if (s.daddr == `RERC_MASK_ADDR)
            begin
                next_s.mask = I_HWDATA[1:0];
            end
        end

        // phase transitions
        unique case (s.phase)
            PH_OFF:
            begin
                // only a soft press starts the system
                if (pressed && !hard)
                begin
                    next_s.phase = PH_RAMP;
                end
            end
            PH_RAMP:
            begin
                if (!pressed && !hold && !core)
                begin
                    next_s.phase = PH_OFF;
                end
                else if (pok)
                begin
                    next_s.phase = PH_BOOT;
                end
            end
            PH_BOOT:
            begin
                if (!pressed && !hold && !core)
                begin
                    next_s.phase = PH_OFF;
                end
                else if (timer_done && !s.manual && (hold || core))
                begin
                    next_s.phase = PH_RUN;
                end
            end
            PH_RUN:
            begin
                // a held button keeps the system up
                if (!hold && !core && !pressed)
                begin
                    next_s.phase = PH_OFF;
                end
            end
        endcase

        // manual reset: set by a hard press, ends after release and time-out
        if (next_s.phase == PH_OFF)
        begin
            next_s.manual = 1'b0;
        end
        else if (s.phase != PH_OFF && hard)
        begin
            next_s.manual = 1'b1;
        end
        else if (!pressed && timer_done)
        begin
            next_s.manual = 1'b0;
        end

        // rail enables per phase
        unique case (next_s.phase)
            PH_OFF:
            begin
                next_s.rail = 7'h00;
            end
            PH_RAMP:
            begin
                next_s.rail = CH1_RAIL;
            end
            PH_BOOT:
            begin
                next_s.rail = hold_set(1'b1) | (core ? CORE_RAILS : 7'h00);
                next_s.rail = next_s.rail | (s.aux_sw ? AUX_RAILS : 7'h00);
            end
            PH_RUN:
            begin
                next_s.rail = hold_set(hold || pressed) | (core ? CORE_RAILS : 7'h00);
                next_s.rail = next_s.rail | (s.aux_sw ? AUX_RAILS : 7'h00);
            end
        endcase

        // reset held low off, ramping, until time-out, and on manual reset
        next_s.rst_oe = (next_s.phase == PH_OFF) || (next_s.phase == PH_RAMP)
                      || (next_s.phase == PH_BOOT && (s.phase != PH_BOOT || !timer_done))
                      || next_s.manual;

        // button status follows the button
        next_s.btn_oe = pressed;

        // interrupt is a level of the unmasked sources
        next_s.irq_oe = (supply_low & s.mask[`RERC_MASK_SUPPLY_BIT])
                      | (fault & s.mask[`RERC_MASK_FAULT_BIT]);
    end

    // one register for all state; reset puts the system off and masked
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_NRST)
        begin
            s <= '0;
            s.phase <= PH_OFF;
            s.aux_sw <= `RERC_CTRL_RESET;
            s.mask <= `RERC_MASK_RESET;
            s.rst_oe <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // zero-wait slave, always OKAY
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_HRDATA = s.hrdata;

    // open-drain pins only ever pull low
    assign O_RAIL_ENABLE = s.rail;
    assign O_PROCESSOR_RESET_OUT_N = 1'b0;
    assign O_PROCESSOR_RESET_OUT_N_OE = s.rst_oe;
    assign O_BUTTON_STATE_OUT_N = 1'b0;
    assign O_BUTTON_STATE_OUT_N_OE = s.btn_oe;
    assign O_INTERRUPT_OUT_N = 1'b0;
    assign O_INTERRUPT_OUT_N_OE = s.irq_oe;

    // checks on the synchronised view of the pins
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_NRST);

    // hard press while the system is up
    sequence s_hard_press;
        s.phase != PH_OFF && hard;
    endsequence

    // channel 1 good while ramping
    sequence s_ch1_good;
        s.phase == PH_RAMP && pok && (pressed || hold || core);
    endsequence

    property p_sleep_rails;
        s.phase == PH_RUN && hold && !core && !s.aux_sw && !pressed |=> s.rail == 7'h13;
    endproperty
    a_sleep_rails: assert property (p_sleep_rails) else $error("sleep rails wrong");
    property p_normal_rails;
        s.phase == PH_RUN && hold && core && !s.aux_sw |=> s.rail == 7'h1f;
    endproperty
    a_normal_rails: assert property (p_normal_rails) else $error("normal rails wrong");
    property p_all_on;
        s.phase == PH_RUN && hold && core && s.aux_sw |=> s.rail == 7'h7f;
    endproperty
    a_all_on: assert property (p_all_on) else $error("not all rails on");
    property p_all_off;
        s.phase == PH_RUN && !hold && !core && !pressed |=> s.phase == PH_OFF && s.rail == 7'h00;
    endproperty
    a_all_off: assert property (p_all_off) else $error("rails not off");
    property p_core_rails;
        s.phase == PH_RUN && core |=> s.rail[3:2] == 2'b11;
    endproperty
    a_core_rails: assert property (p_core_rails) else $error("core rails not on");
    property p_manual_reset;
        s_hard_press |=> s.rst_oe && s.manual ##1 s.rst_oe;
    endproperty
    a_manual_reset: assert property (p_manual_reset) else $error("manual reset not held");
    property p_button_state;
        pressed |=> O_BUTTON_STATE_OUT_N_OE;
    endproperty
    a_button_state: assert property (p_button_state) else $error("button state not driven");
    property p_boot_reset;
        $rose(s.phase == PH_BOOT) |-> s.rst_oe && !timer_done;
    endproperty
    a_boot_reset: assert property (p_boot_reset) else $error("reset released at boot entry");
    property p_irq_level;
        (supply_low && s.mask[0]) || (fault && s.mask[1]) |=> O_INTERRUPT_OUT_N_OE;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked irq not driven");
    property p_irq_masked;
        s.mask == 2'b00 |=> !O_INTERRUPT_OUT_N_OE;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq driven");
    property p_sequence;
        s_ch1_good |=> s.phase == PH_BOOT && s.rail[1] && s.rail[4] && s.rst_oe;
    endproperty
    a_sequence: assert property (p_sequence) else $error("channels 2,5 not after channel 1");
    property p_abort;
        (s.phase == PH_RAMP || s.phase == PH_BOOT) && !pressed && !hold && !core
            |=> s.phase == PH_OFF && s.rail == 7'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("power-up not aborted");

endmodule : rerc_top

// [verification/rerc_proc_model.sv]
`timescale 1ns/1ps

// processor side: pull-ups, channel 1 supply and hold take-over
module rerc_proc_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_take,
    input wire logic i_ch1_en,
    input wire logic i_rst_o,
    input wire logic i_rst_oe,
    input wire logic i_btn_o,
    input wire logic i_btn_oe,
    input wire logic i_irq_o,
    input wire logic i_irq_oe,
    output logic o_ch1_ok,
    output logic o_hold,
    output logic o_rst_n,
    output logic o_btn_n,
    output logic o_irq_n
);
    logic [1:0] ramp; // channel 1 settling delay

    // open-drain lines, pulled up when released
    assign o_rst_n = i_rst_oe ? i_rst_o : 1'b1;
    assign o_btn_n = i_btn_oe ? i_btn_o : 1'b1;
    assign o_irq_n = i_irq_oe ? i_irq_o : 1'b1;
    assign o_ch1_ok = ramp[1];

    // power-ok trails the enable; hold only once out of reset
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ramp <= 2'h0;
            o_hold <= 1'b0;
        end
        else
        begin
            ramp <= {ramp[0], i_ch1_en};
            o_hold <= i_take & (o_hold | o_rst_n);
        end
    end
endmodule : rerc_proc_model

// [verification/rail_enable_reset_control_bench.sv]
`timescale 1ns/1ps

module rail_enable_reset_control_bench;
    localparam int TO = 12; // short time-out keeps the run brief
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic core = 1'b0;
    logic btn_in_n = 1'b1;
    logic hard = 1'b0;
    logic sup = 1'b0;
    logic flt = 1'b0;
    logic take = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hrdy, hresp, ch1_ok, hold, rst_o, rst_oe, btn_o, btn_oe, irq_o, irq_oe;
    logic rst_n, stat_n, irq_n;
    logic [6:0] rail;
    int n_fail = 0;
    int checks = 0;
    int n;

    // free-running core clock, 25 ns
    always #12.5 clk = ~clk;

    rerc_top #(.RESET_TIMEOUT_CYCLES(TO)) dut (
        .I_CORE_CLK(clk),
        .I_NRST(nrst),
        .I_HOLD_RAIL_ENABLE(hold),
        .I_CORE_RAIL_ENABLE(core),
        .I_PUSH_BUTTON_IN_N(btn_in_n),
        .I_BUTTON_HARD_PULL(hard),
        .I_CH1_POWER_OK(ch1_ok),
        .I_SUPPLY_LOW(sup),
        .I_FAULT(flt),
        .I_HSEL(hsel),
        .I_HADDR(haddr),
        .I_HTRANS(htrans),
        .I_HWRITE(hwrite),
        .I_HSIZE(3'h2),
        .I_HWDATA(hwdata),
        .I_HREADY(hrdy),
        .O_HRDATA(hrdata),
        .O_HREADYOUT(hrdy),
        .O_HRESP(hresp),
        .O_RAIL_ENABLE(rail),
        .O_PROCESSOR_RESET_OUT_N(rst_o),
        .O_PROCESSOR_RESET_OUT_N_OE(rst_oe),
        .O_BUTTON_STATE_OUT_N(btn_o),
        .O_BUTTON_STATE_OUT_N_OE(btn_oe),
        .O_INTERRUPT_OUT_N(irq_o),
        .O_INTERRUPT_OUT_N_OE(irq_oe)
    );

    rerc_proc_model proc (
        .i_clk(clk),
        .i_nrst(nrst),
        .i_take(take),
        .i_ch1_en(rail[0]),
        .i_rst_o(rst_o),
        .i_rst_oe(rst_oe),
        .i_btn_o(btn_o),
        .i_btn_oe(btn_oe),
        .i_irq_o(irq_o),
        .i_irq_oe(irq_oe),
        .o_ch1_ok(ch1_ok),
        .o_hold(hold),
        .o_rst_n(rst_n),
        .o_btn_n(stat_n),
        .o_irq_n(irq_n)
    );

    // closing report, the single exit of the run
    task print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // case inequality so an unknown never matches
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    // a wait that used up its bound ends the run
    task hang(input int k);
        if (k >= 200)
        begin
            n_fail++;
            print_verdict();
        end
    endtask : hang

    // one single word transfer; hold each phase until hready
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (hrdy !== 1'b1 && k < 200);
        hang(k);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (hrdy !== 1'b1 && k < 200);
        hang(k);
        rd = hrdata;
        // the slave never signals an error response
        chk(hresp, 1'b0);
    endtask : bus

    task wait_rail(input logic [6:0] v);
        int k;
        k = 0;
        while (rail !== v && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        hang(k);
    endtask : wait_rail

    // cycles until the reset line is released
    task time_rst(output int k);
        k = 0;
        while (rst_n !== 1'b1 && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        hang(k);
    endtask : time_rst

    task t_reset;
        chk(rail, 7'h00);
        chk(rst_n, 1'b0);
        chk({stat_n, irq_n}, 2'h3);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h100);
    endtask : t_reset

    // soft press, ramp, boot, time-out, processor takes over
    task t_powerup;
        btn_in_n <= 1'b0;
        wait_rail(7'h01);
        chk(rst_n, 1'b0);
        chk(stat_n, 1'b0);
        wait_rail(7'h13);
        chk(rst_n, 1'b0);
        time_rst(n);
        chk(n >= TO - 2 && n <= TO + 2, 1'b1);
        take <= 1'b1;
        cyc(6);
        btn_in_n <= 1'b1;
        cyc(5);
        chk(rail, 7'h13);
        chk(stat_n, 1'b1);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd[11:10], 2'h3);
    endtask : t_powerup

    task t_modes;
        core <= 1'b1;
        cyc(4);
        chk(rail, 7'h1f);
        bus(1'b1, 8'h00, 32'h1);
        cyc(2);
        chk(rail, 7'h7f);
        bus(1'b1, 8'h00, 32'h0);
        core <= 1'b0;
        cyc(4);
        chk(rail, 7'h13);
    endtask : t_modes

    // hard press held past the time-out, then released
    task t_manual;
        hard <= 1'b1;
        btn_in_n <= 1'b0;
        cyc(4);
        chk(rst_n, 1'b0);
        cyc(2 * TO);
        chk(rst_n, 1'b0);
        btn_in_n <= 1'b1;
        hard <= 1'b0;
        time_rst(n);
        chk(n >= TO && n <= TO + 5, 1'b1);
        chk(rail, 7'h13);
    endtask : t_manual

    task t_irq;
        sup <= 1'b1;
        cyc(4);
        chk(irq_n, 1'b1);
        bus(1'b1, 8'h04, 32'h1);
        cyc(4);
        chk(irq_n, 1'b0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_5c13);
        sup <= 1'b0;
        flt <= 1'b1;
        cyc(4);
        chk(irq_n, 1'b1);
        bus(1'b1, 8'h04, 32'h2);
        cyc(4);
        chk(irq_n, 1'b0);
        flt <= 1'b0;
        cyc(4);
        chk(irq_n, 1'b1);
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
    endtask : t_irq

    // hold dropped, then a press the processor never answers
    task t_off_abort;
        take <= 1'b0;
        cyc(6);
        chk(rail, 7'h00);
        btn_in_n <= 1'b0;
        wait_rail(7'h13);
        btn_in_n <= 1'b1;
        cyc(5);
        chk(rail, 7'h00);
    endtask : t_off_abort

    // main sequence
    initial
    begin
        cyc(12);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_powerup();
        t_modes();
        t_manual();
        t_irq();
        t_off_abort();
        print_verdict();
    end
endmodule : rail_enable_reset_control_bench
